// ---- rs_rail_order.sv ----
// Rail order registers behind a two-wire serial slave, with sequencer
//
// Function
// - Register A upper nibble holds the second buck rail order code.
// - Register A lower nibble holds the first buck rail order code.
// - A rail coded zero never joins the sequence and stays off.
// - Power-up enables code one first and code twelve last, ascending.
// - Power-down disables rails in the reverse of the power-up order.
// - Every code field is read/write and resets to a factory option value.
// - Register B holds the fourth buck code high and the third buck code low.
module rs_rail_order
    import rs_pkg::*;
#(
    parameter logic [7:0] RST_ORDER_A = 8'h21,
    parameter logic [7:0] RST_ORDER_B = 8'h43
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Serial control pins
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe,
    // Power request pin
    input  wire logic                  power_req_in,
    // Rail enables and status
    output logic [rs_pkg::RS_RAILS-1:0] rail_en,
    output logic                       seq_busy
);
    import rs_pkg::*;

    rs_seq_if      sif ();
    logic [7:0]    order_a;
    logic [7:0]    order_b;
    logic [2:0]    sy_s1, sy_s2, sy_s3;
    logic [2:0]    sy_q;
    logic          scl_d, sda_d;
    logic          scl_rise, scl_fall, start_ev, stop_ev;
    rs_i2c_state_t state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic [7:0]    tx;
    logic [7:0]    ptr;
    logic          rw;
    logic          nack;
    logic [7:0]    rd_data;
    logic [7:0]    rd_next;
    logic          next_sda_oe;
    // Idle pin levels: serial clock and data high, power request low
    localparam logic [2:0] SYNC_IDLE = 3'h3;

    // Three-stage pin sync; value moves once stages two and three agree
    for (genvar i = 0; i < 3; i++) begin : g_sync
        logic pin;
        assign pin = (i == 0) ? scl_in : ((i == 1) ? sda_in : power_req_in);
        always_ff @(posedge mclk) begin
            if (rst) begin
                // Reset to the idle level so no false request follows reset
                sy_s1[i] <= SYNC_IDLE[i];
                sy_s2[i] <= SYNC_IDLE[i];
                sy_s3[i] <= SYNC_IDLE[i];
                sy_q[i]  <= SYNC_IDLE[i];
            end else begin
                sy_s1[i] <= pin;
                sy_s2[i] <= sy_s1[i];
                sy_s3[i] <= sy_s2[i];
                if (sy_s2[i] == sy_s3[i]) begin
                    sy_q[i] <= sy_s3[i];
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= sy_q[0];
            sda_d <= sy_q[1];
        end
    end

    assign scl_rise = sy_q[0] && !scl_d;
    assign scl_fall = !sy_q[0] && scl_d;
    assign start_ev = sy_q[0] && scl_d && sda_d && !sy_q[1];
    assign stop_ev  = sy_q[0] && scl_d && !sda_d && sy_q[1];

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] ra,
                                            input logic [7:0] rb);
        logic [7:0] v;
        v = RS_RD_UNMAPPED;
        if (a == RS_OFF_ORDER_A) begin
            v = ra;
        end else if (a == RS_OFF_ORDER_B) begin
            v = rb;
        end
        return v;
    endfunction : reg_read

    assign rd_data = reg_read(ptr, order_a, order_b);
    assign rd_next = reg_read(ptr + 8'h01, order_a, order_b);

    always_ff @(posedge mclk) begin
        if (rst) begin
            state   <= RS_I2C_IDLE;
            bit_cnt <= '0;
            shreg   <= '0;
            tx      <= '0;
            ptr     <= '0;
            rw      <= 1'b0;
            nack    <= 1'b0;
        end else if (start_ev) begin
            state   <= RS_I2C_DEV;
            bit_cnt <= '0;
        end else if (stop_ev) begin
            state <= RS_I2C_IDLE;
        end else if (scl_rise) begin
            if (state == RS_I2C_DEV || state == RS_I2C_PTR || state == RS_I2C_WDATA) begin
                shreg   <= {shreg[6:0], sy_q[1]};
                bit_cnt <= bit_cnt + 1'b1;
            end else if (state == RS_I2C_RDATA_ACK) begin
                nack <= sy_q[1];
            end
        end else if (scl_fall) begin
            case (state)
                RS_I2C_DEV: begin
                    if (bit_cnt == RS_BITS_BYTE) begin
                        if (shreg[7:1] == RS_DEV_ADDR) begin
                            state <= RS_I2C_DEV_ACK;
                            rw    <= shreg[0];
                        end else begin
                            state <= RS_I2C_IDLE;
                        end
                    end
                end
                RS_I2C_DEV_ACK: begin
                    bit_cnt <= '0;
                    if (rw) begin
                        state <= RS_I2C_RDATA;
                        tx    <= rd_data;
                    end else begin
                        state <= RS_I2C_PTR;
                    end
                end
                RS_I2C_PTR: begin
                    if (bit_cnt == RS_BITS_BYTE) begin
                        ptr   <= shreg;
                        state <= RS_I2C_PTR_ACK;
                    end
                end
                RS_I2C_PTR_ACK, RS_I2C_WDATA_ACK: begin
                    bit_cnt <= '0;
                    state   <= RS_I2C_WDATA;
                end
                RS_I2C_WDATA: begin
                    if (bit_cnt == RS_BITS_BYTE) begin
                        ptr   <= ptr + 8'h01;
                        state <= RS_I2C_WDATA_ACK;
                    end
                end
                RS_I2C_RDATA: begin
                    if (bit_cnt == RS_BIT_LAST) begin
                        state <= RS_I2C_RDATA_ACK;
                    end else begin
                        tx      <= {tx[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 1'b1;
                    end
                end
                RS_I2C_RDATA_ACK: begin
                    if (nack) begin
                        state <= RS_I2C_IDLE;
                    end else begin
                        ptr     <= ptr + 8'h01;
                        tx      <= rd_next;
                        bit_cnt <= '0;
                        state   <= RS_I2C_RDATA;
                    end
                end
                default: begin
                    state <= RS_I2C_IDLE;
                end
            endcase
        end
    end

    // Writable code fields, factory reset values
    always_ff @(posedge mclk) begin
        if (rst) begin
            order_a <= RST_ORDER_A;
            order_b <= RST_ORDER_B;
        end else if (scl_fall && state == RS_I2C_WDATA && bit_cnt == RS_BITS_BYTE) begin
            if (ptr == RS_OFF_ORDER_A) begin
                order_a <= shreg;
            end
            if (ptr == RS_OFF_ORDER_B) begin
                order_b <= shreg;
            end
        end
    end

    // Acknowledge slots and read data zeros pull the line low
    always_comb begin
        next_sda_oe = 1'b0;
        if (state == RS_I2C_DEV_ACK || state == RS_I2C_PTR_ACK || state == RS_I2C_WDATA_ACK) begin
            next_sda_oe = 1'b1;
        end else if (state == RS_I2C_RDATA) begin
            next_sda_oe = !tx[7];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sda_oe  <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe  <= next_sda_oe;
            sda_out <= 1'b0;
        end
    end

    assign sif.codes[0]  = order_a[RS_LO_LSB +: RS_CODE_W];
    assign sif.codes[1]  = order_a[RS_HI_LSB +: RS_CODE_W];
    assign sif.codes[2]  = order_b[RS_LO_LSB +: RS_CODE_W];
    assign sif.codes[3]  = order_b[RS_HI_LSB +: RS_CODE_W];
    assign sif.power_req = sy_q[2];

    rs_sequencer u_seq (
        .mclk (mclk),
        .rst  (rst),
        .sif  (sif.seq)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            rail_en  <= '0;
            seq_busy <= 1'b0;
        end else begin
            rail_en  <= sif.rail_en;
            seq_busy <= sif.busy;
        end
    end
endmodule : rs_rail_order

// ---- rs_pkg.sv ----
// Constants, types and register map of the rail order block
package rs_pkg;
    localparam int          RS_RAILS        = 4;
    localparam int          RS_CODE_W       = 4;
    localparam logic [7:0]  RS_OFF_ORDER_A  = 8'h2c;
    localparam logic [7:0]  RS_OFF_ORDER_B  = 8'h2d;
    localparam logic [7:0]  RS_RD_UNMAPPED  = 8'h00;
    localparam logic [3:0]  RS_CODE_OFF     = 4'h0;
    localparam logic [3:0]  RS_SLOT_FIRST   = 4'h1;
    localparam logic [3:0]  RS_SLOT_LAST    = 4'hc;
    localparam int          RS_HI_LSB       = 4;
    localparam int          RS_LO_LSB       = 0;
    // Device address, arbitrary value
    localparam logic [6:0]  RS_DEV_ADDR     = 7'h2a;
    localparam logic [3:0]  RS_BITS_BYTE    = 4'h8;
    localparam logic [3:0]  RS_BIT_LAST     = 4'h7;
    localparam int          RS_CLK_MHZ      = 250;
    localparam int          RS_STEP_NS      = 1000;
    localparam int          RS_STEP_CYC     = (RS_STEP_NS * RS_CLK_MHZ) / 1000;
    localparam int          RS_TMR_W        = 12;
    localparam logic [11:0] RS_STEP_LAST    = 12'(RS_STEP_CYC - 1);

    typedef logic [RS_RAILS-1:0][RS_CODE_W-1:0] rs_codes_t;

    typedef enum logic [1:0] {
        RS_SQ_OFF,
        RS_SQ_UP,
        RS_SQ_ON,
        RS_SQ_DOWN
    } rs_seq_state_t;

    typedef enum logic [3:0] {
        RS_I2C_IDLE,
        RS_I2C_DEV,
        RS_I2C_DEV_ACK,
        RS_I2C_PTR,
        RS_I2C_PTR_ACK,
        RS_I2C_WDATA,
        RS_I2C_WDATA_ACK,
        RS_I2C_RDATA,
        RS_I2C_RDATA_ACK
    } rs_i2c_state_t;
endpackage : rs_pkg

// ---- rs_seq_if.sv ----
// Link between register file and sequencing engine
interface rs_seq_if;
    import rs_pkg::*;
    rs_codes_t              codes;
    logic                   power_req;
    logic [RS_RAILS-1:0]    rail_en;
    logic                   busy;

    modport ctrl (output codes, output power_req, input rail_en, input busy);
    modport seq  (input codes, input power_req, output rail_en, output busy);
endinterface : rs_seq_if

// ---- rs_sequencer.sv ----
// Slot-stepping power-up and power-down engine
module rs_sequencer
    import rs_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Register file side
    rs_seq_if.seq     sif
);
    rs_seq_state_t         state;
    logic [3:0]            slot;
    logic [RS_TMR_W-1:0]   timer;
    logic                  step;

    assign step = (timer == RS_STEP_LAST);

    always_ff @(posedge mclk) begin
        if (rst || state == RS_SQ_OFF || state == RS_SQ_ON || step) begin
            timer <= '0;
        end else begin
            timer <= timer + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= RS_SQ_OFF;
            slot  <= RS_SLOT_FIRST;
        end else begin
            case (state)
                RS_SQ_OFF: begin
                    if (sif.power_req) begin
                        state <= RS_SQ_UP;
                        slot  <= RS_SLOT_FIRST;
                    end
                end
                RS_SQ_UP: begin
                    if (!sif.power_req) begin
                        state <= RS_SQ_DOWN;
                    end else if (step) begin
                        if (slot == RS_SLOT_LAST) begin
                            state <= RS_SQ_ON;
                        end else begin
                            slot <= slot + 1'b1;
                        end
                    end
                end
                RS_SQ_ON: begin
                    if (!sif.power_req) begin
                        state <= RS_SQ_DOWN;
                        slot  <= RS_SLOT_LAST;
                    end
                end
                RS_SQ_DOWN: begin
                    if (sif.power_req) begin
                        state <= RS_SQ_UP;
                    end else if (step) begin
                        if (slot == RS_SLOT_FIRST) begin
                            state <= RS_SQ_OFF;
                        end else begin
                            slot <= slot - 1'b1;
                        end
                    end
                end
                default: begin
                    state <= RS_SQ_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sif.busy <= 1'b0;
        end else begin
            sif.busy <= (state == RS_SQ_UP) || (state == RS_SQ_DOWN);
        end
    end

    for (genvar r = 0; r < RS_RAILS; r++) begin : g_rail
        logic hit;
        assign hit = (sif.codes[r] == slot) && step;
        always_ff @(posedge mclk) begin
            if (rst) begin
                sif.rail_en[r] <= 1'b0;
            end else if (sif.codes[r] == RS_CODE_OFF || sif.codes[r] > RS_SLOT_LAST) begin
                sif.rail_en[r] <= 1'b0;
            end else if (state == RS_SQ_UP && sif.power_req && hit) begin
                sif.rail_en[r] <= 1'b1;
            end else if (state == RS_SQ_DOWN && !sif.power_req && hit) begin
                sif.rail_en[r] <= 1'b0;
            end
        end
    end
endmodule : rs_sequencer

// ---- rs_rail_order_asserts.sv ----
// Port-level checks of the rail order block
module rs_rail_order_asserts
    import rs_pkg::*;
(
    // Clock and reset
    input wire logic                        mclk,
    input wire logic                        rst,
    // Serial pins
    input wire logic                        scl_in,
    input wire logic                        sda_in,
    input wire logic                        sda_out,
    input wire logic                        sda_oe,
    // Power request and rails
    input wire logic                        power_req_in,
    input wire logic [rs_pkg::RS_RAILS-1:0] rail_en,
    input wire logic                        seq_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Cycles spent in the current busy spell
    logic [13:0] busy_cyc;
    always_ff @(posedge mclk) begin
        busy_cyc <= (rst || !seq_busy) ? 14'h0 : busy_cyc + 14'h1;
    end

    sequence s_rail_step;
        seq_busy && $changed(rail_en);
    endsequence
    sequence s_ack_hold;
        sda_oe [*8];
    endsequence

    AST_RST_QUIET:
    assert property (disable iff (1'b0) rst |=> !sda_oe && !seq_busy && rail_en == '0)
        else $error("outputs not quiet after reset");
    AST_OPEN_DRAIN:
    assert property (!sda_out) else $error("data pin driven high");
    AST_ACK_HOLD:
    assert property ($rose(sda_oe) |-> s_ack_hold) else $error("data pull too short");
    AST_OE_SCL_LOW:
    assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
        else $error("data pin changed near clock high");
    AST_RISE_IN_SEQ:
    assert property (|(rail_en & ~$past(rail_en)) |-> $past(seq_busy) || $past(seq_busy, 2))
        else $error("rail enabled outside a sequence");
    AST_SLOT_PAIR:
    assert property (s_rail_step |=> $stable(rail_en) [*8]) else $error("slot split");
    AST_FIRST_SLOT:
    assert property (seq_busy && busy_cyc < 14'd200 |-> $stable(rail_en))
        else $error("rail switched before first slot");
    AST_BUSY_BOUND:
    assert property (seq_busy |-> busy_cyc < 14'd6500) else $error("sequence too long");
endmodule : rs_rail_order_asserts

bind rs_rail_order rs_rail_order_asserts u_chk (
    .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .power_req_in(power_req_in), .rail_en(rail_en), .seq_busy(seq_busy));

// ---- rs_rail_order_tb.sv ----
// Self-checking bench for the rail order block
module rs_rail_order_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rs_pkg::*;
    localparam logic [7:0] RST_A = 8'h12;
    localparam logic [7:0] RST_B = 8'h34;
    logic       mclk, rst, scl_m, sda_m, power_req_in, sda_out, sda_oe, seq_busy, ack;
    logic [3:0] rail_en;
    logic [3:0] rail_q = 4'h0;
    logic [7:0] rd;
    int         err_total, n_tests;
    int         cyc = 0;
    int         t_chg [4] = '{default: 0};
    // Open-drain data line with pull-up
    wire logic  sda_line = sda_m & ~(sda_oe & ~sda_out);

    rs_rail_order #(.RST_ORDER_A(RST_A), .RST_ORDER_B(RST_B)) u_dut (
        .mclk(mclk), .rst(rst), .scl_in(scl_m), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .power_req_in(power_req_in), .rail_en(rail_en), .seq_busy(seq_busy));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Time stamp of the last change of each rail
    always @(negedge mclk) begin
        cyc++;
        for (int i = 0; i < 4; i++) begin
            if (rail_en[i] !== rail_q[i]) t_chg[i] = cyc;
        end
        rail_q = rail_en;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: value %h wanted %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_gap(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            err_total++;
            $display("unexpected at %0t: gap %0d wanted %0d", $time, got, exp);
        end
    endtask : chk_gap
    task automatic half();
        repeat (12) @(negedge mclk);
    endtask : half
    // One bit slot; the line is sampled at the end of the clock high phase
    task automatic put_bit(input logic b);
        sda_m = b;
        half();
        scl_m = 1'b1;
        half();
        ack = sda_line;
        scl_m = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : put_bit
    task automatic start();
        sda_m = 1'b1;
        half();
        scl_m = 1'b1;
        half();
        sda_m = 1'b0;
        half();
        scl_m = 1'b0;
        repeat (4) @(negedge mclk);
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        half();
        scl_m = 1'b1;
        half();
        sda_m = 1'b1;
        half();
    endtask : stop
    // Byte out or in, then an ack slot released by the master
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
            q[i] = ack;
        end
        put_bit(1'b1);
    endtask : xfer
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] q;
        start();
        xfer({RS_DEV_ADDR, 1'b0}, q);
        chk_val({7'h0, ack}, 8'h00);
        xfer(ptr, q);
        chk_val({7'h0, ack}, 8'h00);
        xfer(d, q);
        chk_val({7'h0, ack}, 8'h00);
        stop();
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] q);
        start();
        xfer({RS_DEV_ADDR, 1'b0}, q);
        chk_val({7'h0, ack}, 8'h00);
        xfer(ptr, q);
        start();
        xfer({RS_DEV_ADDR, 1'b1}, q);
        chk_val({7'h0, ack}, 8'h00);
        xfer(8'hff, q);
        stop();
    endtask : rd_reg
    task automatic run_seq(input logic up);
        int n;
        power_req_in = up;
        for (n = 0; n < 100 && seq_busy !== 1'b1; n++) @(negedge mclk);
        if (n == 100) begin
            err_total++;
            $display("unexpected at %0t: sequence never starts", $time);
            print_verdict();
        end
        for (n = 0; n < 5000 && seq_busy !== 1'b0; n++) @(negedge mclk);
        if (n == 5000) begin
            err_total++;
            $display("unexpected at %0t: sequence never ends", $time);
            print_verdict();
        end
    endtask : run_seq

    initial begin
        rst = 1'b1;
        scl_m = 1'b1;
        sda_m = 1'b1;
        ack = 1'b1;
        power_req_in = 1'b0;
        err_total = 0;
        n_tests = 0;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        rd_reg(RS_OFF_ORDER_A, rd);
        chk_val(rd, RST_A);
        rd_reg(RS_OFF_ORDER_B, rd);
        chk_val(rd, RST_B);
        rd_reg(8'h40, rd);
        chk_val(rd, RS_RD_UNMAPPED);
        start();
        xfer({RS_DEV_ADDR ^ 7'h01, 1'b0}, rd);
        chk_val({7'h0, ack}, 8'h01);
        stop();
        // Buck2 code 3, buck1 and buck3 code 12, buck4 left out
        wr_reg(RS_OFF_ORDER_A, 8'h3c);
        wr_reg(RS_OFF_ORDER_B, 8'h0c);
        rd_reg(RS_OFF_ORDER_A, rd);
        chk_val(rd, 8'h3c);
        run_seq(1'b1);
        chk_val({4'h0, rail_en}, 8'h07);
        chk_gap(t_chg[0] - t_chg[1], 9 * RS_STEP_CYC);
        chk_gap(t_chg[2] - t_chg[0], 0);
        run_seq(1'b0);
        chk_val({4'h0, rail_en}, 8'h00);
        chk_gap(t_chg[1] - t_chg[0], 9 * RS_STEP_CYC);
        chk_gap(t_chg[2] - t_chg[0], 0);
        // Buck3 code 1, buck4 code 13 which stays unused
        wr_reg(RS_OFF_ORDER_B, 8'hd1);
        run_seq(1'b1);
        chk_val({4'h0, rail_en}, 8'h07);
        chk_gap(t_chg[1] - t_chg[2], 2 * RS_STEP_CYC);
        chk_gap(t_chg[0] - t_chg[2], 11 * RS_STEP_CYC);
        run_seq(1'b0);
        chk_val({4'h0, rail_en}, 8'h00);
        chk_gap(t_chg[2] - t_chg[1], 2 * RS_STEP_CYC);
        // Request dropped inside slot three turns the walk back down
        power_req_in = 1'b1;
        repeat (2 * RS_STEP_CYC + 100) @(negedge mclk);
        chk_val({4'h0, rail_en}, 8'h04);
        run_seq(1'b0);
        chk_val({4'h0, rail_en}, 8'h00);
        print_verdict();
    end
endmodule : rs_rail_order_tb
